// ---- include/upc_pkg.sv ----
`default_nettype none
package upc_pkg;

  // Clock period of MCLK_I and the shortest chip reset that counts as a reset.
  localparam int CLK_PERIOD_NS    = 10;
  localparam int CHIP_RST_MIN_NS  = 1000;
  localparam int CHIP_RST_MIN_CYC =
    (CHIP_RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W        = 8;

  // Width of the shared port data bus and its idle value.
  localparam int         DATA_W   = 8;
  localparam logic [7:0] BUS_IDLE = 8'h00;

  // Default length of a VBUS pulse for session request, in cycles.
  localparam int VBUS_PULSE_CYC = 16;
  localparam int VBUS_CNT_W     = 8;

  typedef enum logic [2:0] {
    UPC_SUSPEND,
    UPC_IDLE,
    UPC_RECV,
    UPC_TURN,
    UPC_SEND
  } upc_state_e;

  // Byte offered by the device core for sending to the link.
  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } upc_tx_s;

  // Byte received from the link, with the end-of-stream mark.
  typedef struct packed {
    logic              valid;
    logic              last;
    logic [DATA_W-1:0] data;
  } upc_rx_s;

  // Whole state of the port block.
  typedef struct packed {
    logic                  rstl_m;
    logic                  rstl_s;
    logic                  rstl_d;
    logic                  rclk_m;
    logic                  rclk_s;
    logic                  rclk_d;
    logic                  pclk_m;
    logic                  pclk_s;
    logic                  rate_m;
    logic                  rate_s;
    logic                  stp_m;
    logic                  stp_s;
    logic [DATA_W-1:0]     dat_m;
    logic [DATA_W-1:0]     dat_s;
    logic                  vb_m;
    logic                  vb_s;
    logic [RST_CNT_W-1:0]  low_cnt;
    logic                  clk_in_mode;
    logic                  rate_sel;
    logic                  pclk_div;
    upc_state_e            st;
    logic [DATA_W-1:0]     held;
    logic                  held_v;
    logic                  dir;
    logic                  nxt;
    logic [DATA_W-1:0]     dout;
    logic                  doe;
    logic                  ctl_oe;
    logic                  clk_oe;
    logic                  reg_en;
    upc_rx_s               rx;
    logic [VBUS_CNT_W-1:0] vb_cnt;
  } upc_state_s;

endpackage : upc_pkg
`default_nettype wire

// ---- src/upc_port.sv ----
// Behaviour
// RL1 - Raise DIR to own bus when sending.
// RL2 - Idle: DIR low, watch bus for commands.
// RL3 - NXT high marks presented byte as taken.
// RL4 - Link ends stream with one-cycle STP.
// RL5 - STP marks previous cycle byte as last.
// RL6 - Clock-out: drive port clock, launch on rise.
// RL7 - Port clock pin tied high: clock-in mode.
// RL8 - Clock-in: link supplies reference clock.
// RL9 - Rate strap picks reference frequency.
// RL10 - Chip reset low: suspended, regulators off.
// RL11 - Chip reset accepted asynchronously.
// RL12 - Reset pulse of 1us clears all state.
// RL13 - Chip reset low: all port pins tri-state.
// RL14 - Eight-bit bus, bit 7 most significant.
// RL15 - VBUS feeds comparators and SRP pulsing.
// RL16 - Link releases bus while DIR high.
`default_nettype none
module upc_port #(
  parameter int VBUS_PULSE = upc_pkg::VBUS_PULSE_CYC
) (
  // Clock and reset.
  input  wire logic                     MCLK_I,
  input  wire logic                     SRST_I,
  // Chip pins: reset, straps, reference clock.
  input  wire logic                     CHIP_RESET_LOW_N_I,
  input  wire logic                     RATE_STRAP_I,
  input  wire logic                     REFERENCE_CLOCK_INPUT_I,
  // Port clock pin, three signals.
  input  wire logic                     PORT_CLOCK_PIN_I,
  output logic                          PORT_CLOCK_PIN_O,
  output logic                          PORT_CLOCK_PIN_OE_O,
  // Port handshake pins.
  input  wire logic                     STP_I,
  output logic                          DIR_O,
  output logic                          NXT_O,
  output logic                          CTL_OE_O,
  // Port data bus, three signals.
  input  wire logic [upc_pkg::DATA_W-1:0] DATA_I,
  output logic      [upc_pkg::DATA_W-1:0] DATA_O,
  output logic                          DATA_OE_O,
  // Device core stream towards the link.
  input  wire upc_pkg::upc_tx_s         TX_I,
  output logic                          TX_READY_O,
  // Device core stream from the link.
  output upc_pkg::upc_rx_s              RX_O,
  // Mode, supply and VBUS signals.
  output logic                          CLK_IN_MODE_O,
  output logic                          RATE_SEL_O,
  output logic                          REG_EN_O,
  input  wire logic                     VBUS_CMP_I,
  output logic                          VBUS_VALID_O,
  input  wire logic                     SRP_REQ_I,
  output logic                          VBUS_PULSE_O
);

  upc_pkg::upc_state_s q;
  upc_pkg::upc_state_s next_q;
  logic                step;
  logic                release_ev;
  logic                long_low;

  // Reset value of the whole state; low_cnt starts saturated so the first
  // release after SRST_I captures the straps.
  function automatic upc_pkg::upc_state_s reset_state();
    upc_pkg::upc_state_s r;
    r         = '0;
    r.st      = upc_pkg::UPC_SUSPEND;
    r.low_cnt = upc_pkg::RST_CNT_W'(upc_pkg::CHIP_RST_MIN_CYC);
    r.dout    = upc_pkg::BUS_IDLE;
    return r;
  endfunction : reset_state

  // Port step: rising edge of the port clock in either mode. In clock-out
  // mode the divider rises at this edge; in clock-in mode the synchronised
  // reference clock has just risen. The edge detect reads only the second
  // and third flops, never the first.
  assign step       = q.clk_in_mode ? (q.rclk_s & ~q.rclk_d)
                                    : ~q.pclk_div; // see RL6 see RL8
  assign release_ev = q.rstl_s & ~q.rstl_d; // see RL11
  assign long_low   =
    q.low_cnt >= upc_pkg::RST_CNT_W'(upc_pkg::CHIP_RST_MIN_CYC);

  // Bytes leave the core only in the step that puts them on the bus.
  assign TX_READY_O = q.rstl_s && q.st == upc_pkg::UPC_SEND && step &&
                      !q.stp_s; // see RL1

  // Next-state logic.
  always_comb begin
    next_q          = q;
    next_q.rx.valid = 1'b0;
    next_q.rx.last  = 1'b0;
    // Two-flop synchronisers for every pin input.
    next_q.rstl_m   = CHIP_RESET_LOW_N_I; // see RL11
    next_q.rstl_s   = q.rstl_m;
    next_q.rstl_d   = q.rstl_s;
    next_q.rclk_m   = REFERENCE_CLOCK_INPUT_I;
    next_q.rclk_s   = q.rclk_m;
    next_q.rclk_d   = q.rclk_s;
    next_q.pclk_m   = PORT_CLOCK_PIN_I;
    next_q.pclk_s   = q.pclk_m;
    next_q.rate_m   = RATE_STRAP_I;
    next_q.rate_s   = q.rate_m;
    next_q.stp_m    = STP_I;
    next_q.stp_s    = q.stp_m;
    next_q.dat_m    = DATA_I; // see RL14
    next_q.dat_s    = q.dat_m;
    next_q.vb_m     = VBUS_CMP_I; // see RL15
    next_q.vb_s     = q.vb_m;
    // The divider runs freely; it is only seen on the pin in clock-out mode.
    next_q.pclk_div = ~q.pclk_div; // see RL6
    // Session request pulse on VBUS, restarted by each request.
    if (SRP_REQ_I && q.rstl_s) begin
      next_q.vb_cnt = upc_pkg::VBUS_CNT_W'(VBUS_PULSE); // see RL15
    end else if (q.vb_cnt != '0) begin
      next_q.vb_cnt = q.vb_cnt - upc_pkg::VBUS_CNT_W'(1);
    end
    if (!q.rstl_s) begin
      // Suspended: regulators off, every port pin released.
      next_q.st     = upc_pkg::UPC_SUSPEND; // see RL10
      next_q.reg_en = 1'b0;
      next_q.ctl_oe = 1'b0; // see RL13
      next_q.clk_oe = 1'b0;
      next_q.doe    = 1'b0;
      next_q.dir    = 1'b0;
      next_q.nxt    = 1'b0;
      next_q.vb_cnt = '0;
      if (!long_low) begin
        next_q.low_cnt = q.low_cnt + upc_pkg::RST_CNT_W'(1);
      end
    end else if (q.st == upc_pkg::UPC_SUSPEND) begin
      // Leaving suspend. A pulse that was long enough clears the state and
      // recaptures the straps while the port clock pin is still released;
      // a shorter glitch resumes with the previous mode.
      if (long_low) begin
        next_q             = reset_state(); // see RL12
        next_q.rstl_m      = CHIP_RESET_LOW_N_I;
        next_q.rstl_s      = q.rstl_m;
        next_q.rstl_d      = q.rstl_s;
        next_q.pclk_div    = ~q.pclk_div;
        next_q.clk_in_mode = q.pclk_s; // see RL7
        next_q.rate_sel    = q.rate_s; // see RL9
        next_q.clk_oe      = ~q.pclk_s; // see RL7
      end else begin
        next_q.clk_oe = ~q.clk_in_mode;
      end
      next_q.st      = upc_pkg::UPC_IDLE;
      next_q.low_cnt = '0;
      next_q.reg_en  = 1'b1;
      next_q.ctl_oe  = 1'b1;
    end else if (step) begin
      case (q.st)
        upc_pkg::UPC_IDLE: begin
          // Bus belongs to the link; a non-idle byte opens a command.
          next_q.dir = 1'b0; // see RL2
          if (q.dat_s != upc_pkg::BUS_IDLE) begin
            // NXT accepts the command byte. The byte that the link shows
            // while it samples NXT leaves the synchroniser one step later
            // with the reference clock in, but two steps later with our
            // own clock out, so clock-out waits one quiet turnaround step.
            if (q.clk_in_mode) begin
              next_q.st = upc_pkg::UPC_RECV;
            end else begin
              next_q.st = upc_pkg::UPC_TURN;
            end
            next_q.held_v = 1'b0;
            next_q.nxt    = 1'b1; // see RL3
          end else if (TX_I.valid) begin
            // Take the bus; one turnaround step before driving it.
            next_q.dir = 1'b1; // see RL1 see RL16
            next_q.st  = upc_pkg::UPC_TURN;
          end
        end
        upc_pkg::UPC_RECV: begin
          if (q.stp_s) begin
            // The byte of the previous step was the last one.
            next_q.rx.valid = q.held_v; // see RL5
            next_q.rx.last  = q.held_v;
            next_q.rx.data  = q.held;
            next_q.held_v   = 1'b0;
            next_q.nxt      = 1'b0;
            next_q.st       = upc_pkg::UPC_IDLE;
          end else begin
            // Every step takes the presented byte and passes the one
            // before, so the last byte is known only when STP shows.
            next_q.rx.valid = q.held_v; // see RL3
            next_q.rx.data  = q.held;
            next_q.held     = q.dat_s;
            next_q.held_v   = 1'b1;
            next_q.nxt      = 1'b1;
          end
        end
        upc_pkg::UPC_TURN: begin
          // One quiet step while the bus changes hands: the data
          // synchroniser still holds bytes from before the change. DIR
          // leads on to sending, NXT to a command, neither back to idle.
          if (q.dir) begin
            next_q.st = upc_pkg::UPC_SEND;
          end else if (q.nxt) begin
            next_q.st = upc_pkg::UPC_RECV; // see RL3
          end else begin
            next_q.st = upc_pkg::UPC_IDLE;
          end
        end
        upc_pkg::UPC_SEND: begin
          if (q.stp_s || !TX_I.valid) begin
            // Link stop or nothing left: hand the bus back.
            // Our own last byte is still in the synchroniser, so one
            // quiet step passes before link commands are watched again.
            next_q.dir = 1'b0; // see RL2 see RL4
            next_q.doe = 1'b0;
            next_q.st  = upc_pkg::UPC_TURN;
          end else begin
            next_q.dout = TX_I.data; // see RL14
            next_q.doe  = 1'b1; // see RL1
          end
        end
        default: begin
          next_q.st = upc_pkg::UPC_IDLE;
        end
      endcase
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      q <= reset_state();
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from the state.
  assign PORT_CLOCK_PIN_O    = q.pclk_div;
  assign PORT_CLOCK_PIN_OE_O = q.clk_oe;
  assign DIR_O               = q.dir;
  assign NXT_O               = q.nxt;
  assign CTL_OE_O            = q.ctl_oe;
  assign DATA_O              = q.dout;
  assign DATA_OE_O           = q.doe;
  assign RX_O                = q.rx;
  assign CLK_IN_MODE_O       = q.clk_in_mode;
  assign RATE_SEL_O          = q.rate_sel;
  assign REG_EN_O            = q.reg_en;
  assign VBUS_VALID_O        = q.vb_s;
  assign VBUS_PULSE_O        = q.vb_cnt != '0;

  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);

  // Driving the bus always comes with DIR high.
  bus_owner_a : assert property ( // see RL1
    DATA_OE_O |-> DIR_O) else $error("data driven with DIR low");

  // Idle keeps DIR low.
  idle_dir_a : assert property ( // see RL2
    q.st == upc_pkg::UPC_IDLE && !$past(TX_I.valid) |-> !DIR_O)
    else $error("DIR high while idle");

  // Entering receive takes the first byte with NXT.
  recv_nxt_a : assert property ( // see RL3
    $rose(q.st == upc_pkg::UPC_RECV) |-> NXT_O && !DIR_O)
    else $error("receive entered without NXT");

  // STP closes the stream with the held byte marked last.
  stp_last_a : assert property ( // see RL5
    q.rstl_s && step && q.st == upc_pkg::UPC_RECV && q.stp_s && q.held_v
    |=> RX_O.valid && RX_O.last && RX_O.data == $past(q.held) &&
        q.st == upc_pkg::UPC_IDLE) else $error("last byte not marked");

  // In clock-out mode the pin toggles every cycle.
  clk_out_a : assert property ( // see RL6
    PORT_CLOCK_PIN_OE_O |=> PORT_CLOCK_PIN_O != $past(PORT_CLOCK_PIN_O))
    else $error("port clock not toggling");

  // Clock-in mode never drives the port clock pin.
  clk_in_a : assert property ( // see RL7
    CLK_IN_MODE_O |-> !PORT_CLOCK_PIN_OE_O)
    else $error("port clock driven in clock-in mode");

  // The rate strap is only taken at a reset release.
  rate_hold_a : assert property ( // see RL9
    $changed(RATE_SEL_O) |-> $past(release_ev))
    else $error("rate select changed outside release");

  // Chip reset low suspends within one cycle of the synchroniser.
  suspend_a : assert property ( // see RL10 see RL11
    $fell(q.rstl_s) |=> q.st == upc_pkg::UPC_SUSPEND && !REG_EN_O)
    else $error("not suspended under chip reset");

  // Under chip reset no port pin is driven.
  tristate_a : assert property ( // see RL13
    !q.rstl_s |=> !DATA_OE_O && !CTL_OE_O && !PORT_CLOCK_PIN_OE_O)
    else $error("port pin driven under chip reset");

  // A long enough reset pulse leaves a clean idle port.
  long_reset_a : assert property ( // see RL12
    release_ev && long_low
    |=> q.st == upc_pkg::UPC_IDLE && !q.held_v && !DIR_O && !NXT_O)
    else $error("state not cleared after reset pulse");

  // A session request pulses VBUS for at least eight cycles.
  vbus_pulse_a : assert property ( // see RL15
    $rose(VBUS_PULSE_O) |-> VBUS_PULSE_O [*8])
    else $error("VBUS pulse too short");

endmodule : upc_port
`default_nettype wire

// ---- dv/upc_link_model.sv ----
`default_nettype none
// Link side of the port: sends a three-byte command and logs bytes received.
module upc_link_model (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Bench control and the port clock level before each edge.
  input  wire logic       start_i,
  input  wire logic       step_ref_i,
  // Port pins as the link sees them.
  input  wire logic       dir_i,
  input  wire logic       nxt_i,
  input  wire logic [7:0] dout_i,
  input  wire logic       doe_i,
  output logic            stp_o,
  output logic [7:0]      bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       pend;
  logic       act;
  logic [1:0] idx;
  logic [7:0] last;
  logic [7:0] got [0:3];
  int         n_got;

  // Nobody driving shows a changing pattern, so a stale byte cannot pass.
  assign bus_o = doe_i ? dout_i :
                 (!dir_i ? (act ? 8'h41 + 8'(idx) : 8'h00) : ~last);

  // The link works only where the port clock rises.
  always_ff @(posedge clk_i) begin
    last <= bus_o;
    if (start_i) pend <= 1'b1;
    if (rst_i) begin
      pend  <= 1'b0;
      act   <= 1'b0;
      idx   <= 2'h0;
      stp_o <= 1'b0;
      n_got <= 0;
    end else if (!step_ref_i) begin
      stp_o <= 1'b0;
      if (dir_i && doe_i && n_got < 4) begin
        got[n_got] <= bus_o;
        n_got      <= n_got + 1;
      end
      if (pend && !dir_i && !act) begin
        pend <= 1'b0;
        act  <= 1'b1;
        idx  <= 2'h0;
      end else if (act && nxt_i) begin
        if (idx == 2'h2) begin
          act   <= 1'b0;
          stp_o <= 1'b1;
        end else idx <= idx + 2'h1;
      end
    end
  end
endmodule : upc_link_model
`default_nettype wire

// ---- dv/ulpi_phy_port_control_tb.sv ----
`default_nettype none
module ulpi_phy_port_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int VBP = 10;
  logic clk = 1'b0, srst = 1'b1, crst_n = 1'b0, strap = 1'b1;
  logic refc = 1'b0, pclk_tie = 1'b0, vcmp = 1'b0, srp = 1'b0;
  logic start = 1'b0;
  logic [1:0] tx_i = 2'h0, tx_n = 2'h0;
  logic pco, pcoe, pcin, stp, dir, nxt, ctloe, doe, txr;
  logic cim, rsel, regen, vval, vpul;
  logic [7:0] dout, bus;
  logic [7:0] r_d [0:7];
  logic [7:0] r_l;
  upc_pkg::upc_tx_s tx;
  upc_pkg::upc_rx_s rx;
  int r_n = 0, fails = 0, tests_run = 0, cyc = 0;

  always #5 clk = ~clk;
  // The link clock runs free; only clock-in mode listens to it.
  always @(posedge clk) refc <= ~refc;
  assign pcin = pcoe ? pco : pclk_tie;
  // Core stream: two bytes with inverted bit patterns.
  always_comb begin
    tx.valid = tx_i < tx_n;
    tx.data  = tx_i[0] ? 8'hC3 : 8'h3C;
  end
  // Advance the core byte when taken, log received bytes, cut hangs.
  always @(posedge clk) begin
    if (txr === 1'b1) tx_i <= tx_i + 2'h1;
    if (rx.valid === 1'b1 && r_n < 8) begin
      r_d[r_n] <= rx.data;
      r_l[r_n] <= rx.last;
      r_n      <= r_n + 1;
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  upc_port #(.VBUS_PULSE(VBP)) u_upc_port (
    .MCLK_I(clk), .SRST_I(srst), .CHIP_RESET_LOW_N_I(crst_n),
    .RATE_STRAP_I(strap), .REFERENCE_CLOCK_INPUT_I(refc),
    .PORT_CLOCK_PIN_I(pcin), .PORT_CLOCK_PIN_O(pco),
    .PORT_CLOCK_PIN_OE_O(pcoe), .STP_I(stp), .DIR_O(dir), .NXT_O(nxt),
    .CTL_OE_O(ctloe), .DATA_I(bus), .DATA_O(dout), .DATA_OE_O(doe),
    .TX_I(tx), .TX_READY_O(txr), .RX_O(rx), .CLK_IN_MODE_O(cim),
    .RATE_SEL_O(rsel), .REG_EN_O(regen), .VBUS_CMP_I(vcmp),
    .VBUS_VALID_O(vval), .SRP_REQ_I(srp), .VBUS_PULSE_O(vpul));
  upc_link_model u_upc_link_model (
    .clk_i(clk), .rst_i(srst), .start_i(start),
    .step_ref_i(cim ? refc : pco), .dir_i(dir), .nxt_i(nxt),
    .dout_i(dout), .doe_i(doe), .stp_o(stp), .bus_o(bus));

  task automatic chk1(string nm, logic e, logic g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask : chk1
  task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk8
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // Holds the chip reset low for n cycles with the given pin straps.
  task automatic chip_rst(int n, logic tie, logic s);
    @(posedge clk);
    crst_n   <= 1'b0;
    pclk_tie <= tie;
    strap    <= s;
    tick(n);
    chk1("ctl_oe", 1'b0, ctloe);
    chk1("data_oe", 1'b0, doe);
    chk1("clk_oe", 1'b0, pcoe);
    chk1("reg_en", 1'b0, regen);
    @(posedge clk);
    crst_n <= 1'b1;
    tick(20);
  endtask : chip_rst
  task automatic t_boot;
    logic p;
    chip_rst(120, 1'b0, 1'b1);
    chk1("clk_in", 1'b0, cim);
    chk1("rate", 1'b1, rsel);
    chk1("reg_en", 1'b1, regen);
    chk1("dir", 1'b0, dir);
    p = pco;
    tick(1);
    chk1("pclk", ~p, pco);
    chk1("clk_oe", 1'b1, pcoe);
  endtask : t_boot
  task automatic t_send;
    int i;
    @(posedge clk);
    tx_n <= 2'h2;
    for (i = 0; i < 60 && dir !== 1'b1; i++) tick(1);
    chk1("dir_up", 1'b1, dir);
    for (i = 0; i < 60 && (dir !== 1'b0 || tx_i != 2'h2); i++) tick(1);
    chk1("dir_down", 1'b0, dir);
    chk1("data_oe", 1'b0, doe);
    chk8("n_sent", 8'h02, 8'(u_upc_link_model.n_got));
    chk8("byte0", 8'h3C, u_upc_link_model.got[0]);
    chk8("byte1", 8'hC3, u_upc_link_model.got[1]);
  endtask : t_send
  // Receives one three-byte command; b is the count logged before it.
  task automatic t_recv(int b);
    int i;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (i = 0; i < 200 && nxt !== 1'b1; i++) tick(1);
    chk1("nxt_up", 1'b1, nxt);
    chk1("dir_rx", 1'b0, dir);
    for (i = 0; i < 200 && r_n < b + 3; i++) tick(1);
    tick(10);
    chk8("n_recv", 8'(b + 3), 8'(r_n));
    chk1("dir", 1'b0, dir);
    chk1("nxt_down", 1'b0, nxt);
    for (i = 0; i < 3; i++) begin
      chk8("rx_data", 8'h41 + 8'(i), r_d[b + i]);
      chk1("rx_last", i == 2, r_l[b + i]);
    end
  endtask : t_recv
  task automatic t_vbus;
    int i;
    int n;
    @(posedge clk);
    vcmp <= 1'b1;
    tick(6);
    chk1("vbus_valid", 1'b1, vval);
    @(posedge clk);
    srp <= 1'b1;
    @(posedge clk);
    srp <= 1'b0;
    tick(1);
    for (i = 0; i < 20 && vpul !== 1'b1; i++) tick(1);
    for (n = 0; n < 50 && vpul === 1'b1; n++) tick(1);
    chk8("vbus_pulse", 8'(VBP), 8'(n));
  endtask : t_vbus
  // A short reset keeps the old straps; a long one recaptures them.
  task automatic t_resets;
    chip_rst(10, 1'b0, 1'b0);
    chk1("rate_kept", 1'b1, rsel);
    chk1("reg_en", 1'b1, regen);
    chip_rst(120, 1'b1, 1'b0);
    chk1("clk_in", 1'b1, cim);
    chk1("clk_oe", 1'b0, pcoe);
    chk1("rate_new", 1'b0, rsel);
  endtask : t_resets
  task automatic end_of_test;
    $display("checks %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // Main sequence after four cycles of system reset.
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_boot();
    t_send();
    t_recv(0);
    t_vbus();
    t_resets();
    // The last reset left the port in clock-in mode.
    t_recv(3);
    end_of_test();
  end
endmodule : ulpi_phy_port_control_tb
`default_nettype wire
